// *** rtl/irm_framer.sv ***
`timescale 1ns/1ps

module irm_framer
(
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port.
  input wire irm_pkg::irm_bus_t bus,
  output logic [31:0] rdata,
  // Optical transceiver.
  input wire logic ir_rx,
  output logic ir_tx
);

  irm_pkg::irm_state_t q;
  irm_pkg::irm_state_t d;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    crc_bit = {c[14:0], 1'b0} ^ (fb ? irm_pkg::CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] v);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = crc_bit(r, v[i]);
    end
    crc_byte = r;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    rev8 = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    logic tx_on;
    logic rx_on;
    logic tick;
    logic bit_v;
    logic stuffed;
    logic rise;
    logic ev;
    logic b;
    logic flag;
    logic stuff;
    logic abt;
    logic bdone;
    logic [7:0] nbyte;
    logic [5:0] len;
    logic dv;
    irm_pkg::irm_rxw_t dw;
    logic [irm_pkg::ST_W-1:0] set;
    logic [irm_pkg::ST_W-1:0] clr;
    logic rd_hit;
    tx_on = 1'b0;
    rx_on = 1'b0;
    tick = 1'b0;
    bit_v = 1'b0;
    stuffed = 1'b0;
    rise = 1'b0;
    ev = 1'b0;
    b = 1'b0;
    flag = 1'b0;
    stuff = 1'b0;
    abt = 1'b0;
    bdone = 1'b0;
    nbyte = '0;
    len = '0;
    dv = 1'b0;
    dw = '0;
    set = '0;
    clr = '0;
    rd_hit = 1'b0;
    d = q;

    tx_on = q.ctl.transmit_enable_bit && (q.ctl.mode == irm_pkg::MODE_MEDIUM);
    rx_on = q.ctl.receive_enable_bit && (q.ctl.mode == irm_pkg::MODE_MEDIUM);

    // Reading the receive word frees it before any new byte is delivered.
    rd_hit = bus.re && (bus.addr == irm_pkg::REG_RXDATA);
    if (rd_hit)
    begin
      d.rx.rxd.v = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////////
    // Transmit path.
    if (!tx_on)
    begin
      // Disabling drops everything queued, so a half frame is never resumed.
      d.tx = '0;
      d.tx.st = irm_pkg::TX_IDLE;
      d.tx.cur = 1'b1;
    end
    else
    begin
      tick = q.ctl.rate | q.tx.pre;
      d.tx.pre = ~q.ctl.rate & ~q.tx.pre;
      if (tick)
      begin
        d.tx.qc = q.tx.qc + 2'h1;
        if (q.tx.qc == irm_pkg::TX_LAST_QUARTER)
        begin
          stuffed = ((q.tx.st == irm_pkg::TX_DATA) || (q.tx.st == irm_pkg::TX_CRC))
                    && (q.tx.ones == irm_pkg::STUFF_RUN);
          if (stuffed)
          begin
            d.tx.cur = 1'b0;
            d.tx.ones = '0;
          end
          else
          begin
            if (q.tx.nb == 5'h00)
            begin
              d.tx.nb = 5'h08;
              d.tx.sh = {8'h00, irm_pkg::FLAG};
              unique case (q.tx.st)
                irm_pkg::TX_IDLE:
                begin
                  d.tx.ones = '0;
                  if (q.tx.hv)
                  begin
                    d.tx.st = irm_pkg::TX_OPEN;
                    d.tx.fc = 1'b1;
                  end
                end
                irm_pkg::TX_OPEN:
                begin
                  if (q.tx.fc)
                  begin
                    d.tx.fc = 1'b0;
                  end
                  else
                  begin
                    d.tx.st = irm_pkg::TX_DATA;
                    d.tx.sh = {8'h00, q.tx.hold};
                    d.tx.hv = 1'b0;
                    d.tx.crc = irm_pkg::CRC_INIT;
                  end
                end
                irm_pkg::TX_DATA:
                begin
                  if (q.tx.hv)
                  begin
                    d.tx.sh = {8'h00, q.tx.hold};
                    d.tx.hv = 1'b0;
                  end
                  else if (q.tx.tn != 2'h0)
                  begin
                    d.tx.sh = {8'h00, q.tx.tail[7:0]};
                    d.tx.tail = {8'h00, q.tx.tail[23:8]};
                    d.tx.tn = q.tx.tn - 2'h1;
                  end
                  else
                  begin
                    d.tx.st = irm_pkg::TX_CRC;
                    d.tx.sh = q.tx.crc;
                    d.tx.nb = 5'h10;
                  end
                end
                irm_pkg::TX_CRC:
                begin
                  d.tx.st = irm_pkg::TX_IDLE;
                  set[irm_pkg::ST_TFC] = 1'b1;
                end
              endcase
            end
            if (d.tx.st == irm_pkg::TX_CRC)
            begin
              bit_v = d.tx.sh[15];
              d.tx.sh = {d.tx.sh[14:0], 1'b0};
            end
            else
            begin
              bit_v = d.tx.sh[0];
              d.tx.sh = {1'b0, d.tx.sh[15:1]};
            end
            d.tx.nb = d.tx.nb - 5'h01;
            d.tx.cur = bit_v;
            if ((d.tx.st == irm_pkg::TX_DATA) || (d.tx.st == irm_pkg::TX_CRC))
            begin
              d.tx.ones = bit_v ? d.tx.ones + 3'h1 : 3'h0;
            end
            if (d.tx.st == irm_pkg::TX_DATA)
            begin
              d.tx.crc = crc_bit(d.tx.crc, bit_v);
            end
          end
        end
      end
      d.tx.out = (d.tx.qc == 2'h0) && !d.tx.cur;
    end

    //////////////////////////////////////////////////////////////////////////////
    // Receive path: the first synchroniser stage feeds only the second.
    d.rx.sy = {q.rx.sy[1:0], ir_rx};
    if (!rx_on)
    begin
      d.rx = '0;
      d.rx.st = irm_pkg::RX_HUNT;
      d.rx.sy = {q.rx.sy[1:0], ir_rx};
    end
    else
    begin
      len = (q.rx.ph == irm_pkg::RX_SHORT_PHASE) ? irm_pkg::RX_SHORT : irm_pkg::RX_LONG;
      rise = q.rx.sy[1] && !q.rx.sy[2];
      if (rise)
      begin
        // An edge just after a window closed belongs to the new window already.
        ev = (q.rx.cnt >= irm_pkg::RX_HALF);
        b = !q.rx.seen;
        d.rx.cnt = '0;
        d.rx.seen = 1'b1;
      end
      else if (q.rx.cnt == len - 6'h01)
      begin
        ev = 1'b1;
        b = !q.rx.seen;
        d.rx.cnt = '0;
        d.rx.seen = 1'b0;
      end
      else
      begin
        d.rx.cnt = q.rx.cnt + 6'h01;
      end
      if (ev)
      begin
        d.rx.ph = (q.rx.ph == irm_pkg::RX_SHORT_PHASE) ? 2'h0 : q.rx.ph + 2'h1;
      end

      if (ev)
      begin
        flag = !b && (q.rx.run == irm_pkg::FLAG_RUN);
        stuff = !b && (q.rx.run == irm_pkg::STUFF_RUN);
        abt = b && (q.rx.run == irm_pkg::FLAG_RUN);
        if (b)
        begin
          d.rx.run = (q.rx.run == irm_pkg::MAX_RUN) ? q.rx.run : q.rx.run + 3'h1;
        end
        else
        begin
          d.rx.run = '0;
        end
        nbyte = {b, q.rx.sh[7:1]};
        bdone = !flag && !stuff && !abt && (q.rx.bc == 3'h7);
        if (!flag && !stuff && !abt)
        begin
          d.rx.sh = nbyte;
          d.rx.bc = q.rx.bc + 3'h1;
        end
        unique case (q.rx.st)
          irm_pkg::RX_HUNT, irm_pkg::RX_SKIP:
          begin
            if (flag)
            begin
              d.rx.st = irm_pkg::RX_SYNC;
              d.rx.bc = '0;
            end
          end
          irm_pkg::RX_SYNC:
          begin
            if (flag)
            begin
              d.rx.bc = '0;
            end
            else if (abt)
            begin
              d.rx.st = irm_pkg::RX_HUNT;
            end
            else if (bdone)
            begin
              if (q.ctl.match_en && (nbyte != q.maddr) && (nbyte != irm_pkg::BCAST))
              begin
                d.rx.st = irm_pkg::RX_SKIP;
              end
              else
              begin
                d.rx.st = irm_pkg::RX_FRAME;
                d.rx.t0 = nbyte;
                d.rx.tc = 2'h1;
                d.rx.pv = 1'b0;
                d.rx.crc = irm_pkg::CRC_INIT;
              end
            end
          end
          irm_pkg::RX_FRAME:
          begin
            if (flag && (q.rx.bc == 3'h7) && (q.rx.tc == 2'h2) && q.rx.pv)
            begin
              // The two held bytes are the CRC, each assembled in reverse order.
              dv = 1'b1;
              dw.data = q.rx.pend;
              dw.eof = 1'b1;
              dw.crce = (q.rx.crc != {rev8(q.rx.t0), rev8(q.rx.t1)});
              set[irm_pkg::ST_RFC] = 1'b1;
              set[irm_pkg::ST_CRCE] = dw.crce;
              d.rx.st = irm_pkg::RX_SYNC;
              d.rx.bc = '0;
            end
            else if (flag || abt)
            begin
              dv = q.rx.pv;
              dw.data = q.rx.pend;
              dw.eof = 1'b1;
              dw.rab = 1'b1;
              set[irm_pkg::ST_RAB] = 1'b1;
              d.rx.st = flag ? irm_pkg::RX_SYNC : irm_pkg::RX_HUNT;
              d.rx.bc = '0;
            end
            else if (bdone)
            begin
              if (q.rx.tc == 2'h2)
              begin
                d.rx.crc = crc_byte(q.rx.crc, q.rx.t0);
                dv = q.rx.pv;
                dw.data = q.rx.pend;
                d.rx.pend = q.rx.t0;
                d.rx.pv = 1'b1;
                d.rx.t0 = q.rx.t1;
                d.rx.t1 = nbyte;
              end
              else
              begin
                d.rx.t1 = nbyte;
                d.rx.tc = 2'h2;
              end
            end
          end
        endcase
      end
      if (dv)
      begin
        if (d.rx.rxd.v)
        begin
          set[irm_pkg::ST_ROR] = 1'b1;
        end
        else
        begin
          d.rx.rxd = dw;
          d.rx.rxd.v = 1'b1;
        end
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Register port.
    d.rdata = '0;
    if (bus.re)
    begin
      unique case (bus.addr)
        irm_pkg::REG_CTRL: d.rdata = {26'h0, q.ctl};
        irm_pkg::REG_ADDR: d.rdata = {24'h0, q.maddr};
        irm_pkg::REG_TXDATA: d.rdata = {30'h0, q.tx.st != irm_pkg::TX_IDLE, q.tx.hv};
        irm_pkg::REG_RXDATA: d.rdata = {20'h0, q.rx.rxd};
        irm_pkg::REG_STATUS: d.rdata = {27'h0, q.st};
        default: d.rdata = '0;
      endcase
    end
    if (bus.we)
    begin
      unique case (bus.addr)
        irm_pkg::REG_CTRL: d.ctl = bus.wdata[5:0];
        irm_pkg::REG_ADDR: d.maddr = bus.wdata[7:0];
        irm_pkg::REG_STATUS: clr = bus.wdata[irm_pkg::ST_W-1:0];
        irm_pkg::REG_TXDATA:
        begin
          if (tx_on && !d.tx.hv)
          begin
            d.tx.hold = bus.wdata[7:0];
            d.tx.hv = 1'b1;
          end
        end
        irm_pkg::REG_TAIL1, irm_pkg::REG_TAIL2, irm_pkg::REG_TAIL3:
        begin
          if (tx_on && (d.tx.tn == 2'h0))
          begin
            d.tx.tail = bus.wdata[23:0];
            d.tx.tn = bus.addr[3:2];
          end
        end
        default: d.rdata = d.rdata;
      endcase
    end
    // A new event in the cycle of its clear keeps the bit set.
    d.st = (q.st & ~clr) | set;
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
      q.ctl <= irm_pkg::CTRL_RESET;
      q.tx.st <= irm_pkg::TX_IDLE;
      q.tx.cur <= 1'b1;
      q.rx.st <= irm_pkg::RX_HUNT;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign ir_tx = q.tx.out;

endmodule

// *** pkg/irm_pkg.sv ***
package irm_pkg;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_TAIL1 = 8'h14;
  localparam logic [7:0] REG_TAIL2 = 8'h18;
  localparam logic [7:0] REG_TAIL3 = 8'h1C;

  // Control register field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TXE = 2;
  localparam int CTRL_RXE = 3;
  localparam int CTRL_RATE = 4;
  localparam int CTRL_MATCH = 5;
  localparam logic [1:0] MODE_MEDIUM = 2'h2;

  // Status register bit positions.
  localparam int ST_TFC = 0;
  localparam int ST_RFC = 1;
  localparam int ST_CRCE = 2;
  localparam int ST_RAB = 3;
  localparam int ST_ROR = 4;
  localparam int ST_W = 5;

  // Line coding constants.
  localparam logic [7:0] FLAG = 8'h7E;
  localparam logic [7:0] BCAST = 8'hFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] FLAG_RUN = 3'h6;
  localparam logic [2:0] MAX_RUN = 3'h7;

  // Clock division: transmit in quarter-bit ticks, receive in source clock cycles.
  localparam logic [1:0] TX_LAST_QUARTER = 2'h3;
  localparam int RX_DIV_NUM = 125;
  localparam int RX_DIV_DEN = 3;
  localparam logic [5:0] RX_LONG = 6'((RX_DIV_NUM + RX_DIV_DEN - 1) / RX_DIV_DEN);
  localparam logic [5:0] RX_SHORT = 6'(RX_DIV_NUM / RX_DIV_DEN);
  localparam logic [5:0] RX_HALF = 6'(RX_DIV_NUM / RX_DIV_DEN / 2);
  localparam logic [1:0] RX_SHORT_PHASE = 2'h2;

  typedef struct packed {
    logic re;
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
  } irm_bus_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_OPEN = 4'b0010,
    TX_DATA = 4'b0100,
    TX_CRC = 4'b1000
  } irm_tx_st_t;

  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_SYNC = 4'b0010,
    RX_FRAME = 4'b0100,
    RX_SKIP = 4'b1000
  } irm_rx_st_t;

  typedef struct packed {
    logic match_en;
    logic rate;
    logic receive_enable_bit;
    logic transmit_enable_bit;
    logic [1:0] mode;
  } irm_ctl_t;

  localparam irm_ctl_t CTRL_RESET = '0;

  typedef struct packed {
    logic v;
    logic rab;
    logic crce;
    logic eof;
    logic [7:0] data;
  } irm_rxw_t;

  typedef struct packed {
    irm_tx_st_t st;
    logic pre;
    logic [1:0] qc;
    logic cur;
    logic [15:0] sh;
    logic [4:0] nb;
    logic [2:0] ones;
    logic fc;
    logic [15:0] crc;
    logic hv;
    logic [7:0] hold;
    logic [23:0] tail;
    logic [1:0] tn;
    logic out;
  } irm_tx_t;

  typedef struct packed {
    irm_rx_st_t st;
    logic [2:0] sy;
    logic [5:0] cnt;
    logic [1:0] ph;
    logic seen;
    logic [2:0] run;
    logic [7:0] sh;
    logic [2:0] bc;
    logic [7:0] t0;
    logic [7:0] t1;
    logic [1:0] tc;
    logic [7:0] pend;
    logic pv;
    logic [15:0] crc;
    irm_rxw_t rxd;
  } irm_rx_t;

  typedef struct packed {
    irm_ctl_t ctl;
    logic [7:0] maddr;
    logic [ST_W-1:0] st;
    logic [31:0] rdata;
    irm_tx_t tx;
    irm_rx_t rx;
  } irm_state_t;

endpackage

// *** test/irm_framer_checker.sv ***
`timescale 1ns/1ps

module irm_framer_checker
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port.
  input wire irm_pkg::irm_bus_t bus,
  input wire logic [31:0] rdata,
  // Optical lines.
  input wire logic ir_rx,
  input wire logic ir_tx
);
  logic ctrl_w_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Until software has touched the control word the transmitter must stay dark.
  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_w_q <= 1'b0;
    else if (bus.we && bus.addr == irm_pkg::REG_CTRL)
      ctrl_w_q <= 1'b1;
  end

  AST_RESET_QUIET: assert property (
    $fell(reset) |-> rdata == 32'h0 && !ir_tx) else $error("outputs not quiet after reset");
  AST_DISABLED_DARK: assert property (
    !ctrl_w_q |-> !ir_tx) else $error("light sent while disabled");
  AST_RDATA_IDLE: assert property (
    $past(clk_en) && !$past(bus.re) |-> rdata == 32'h0) else $error("read data outside slot");
  AST_UNMAPPED: assert property (
    bus.re && bus.addr > 8'h1C |=> rdata == 32'h0) else $error("unmapped read not zero");
  AST_PULSE_WIDTH: assert property (
    $rose(ir_tx) && clk_en |-> ##2 !ir_tx) else $error("pulse longer than a quarter bit");
  AST_PULSE_GAP: assert property (
    $rose(ir_tx) |=> (!$rose(ir_tx)) [*3]) else $error("pulses closer than one bit");
  AST_FLAG_DENSITY: assert property (
    $rose(ir_tx) |-> ##[4:56] $rose(ir_tx)) else $error("more than six ones in a row");
  AST_CTRL_READBACK: assert property (
    bus.we && bus.addr == irm_pkg::REG_CTRL ##1 !bus.we ##1 bus.re && bus.addr ==
    irm_pkg::REG_CTRL |=> rdata[5:0] == $past(bus.wdata[5:0], 3)) else $error("control readback");
  AST_ADDR_READBACK: assert property (
    bus.we && bus.addr == irm_pkg::REG_ADDR ##1 !bus.we ##1 bus.re && bus.addr ==
    irm_pkg::REG_ADDR |=> rdata[7:0] == $past(bus.wdata[7:0], 3)) else $error("address readback");
endmodule

bind irm_framer irm_framer_checker irm_framer_checker_i (.clk(clk), .reset(reset),
  .clk_en(clk_en), .bus(bus), .rdata(rdata), .ir_rx(ir_rx), .ir_tx(ir_tx));

// *** test/irm_link_model.sv ***
`timescale 1ns/1ps

module irm_link_model
(
  // Clock.
  input wire logic clk,
  // Optical lines seen from the remote station.
  input wire logic ir_tx,
  output logic ir_rx
);
  bit out_q[$];
  bit cap_q[$];
  int bit_clk = 4;
  int gap = 0;
  bit seen = 0;
  logic prev = 1'b0;

  // A rise marks a zero; the dark bit slots before it are ones.
  always @(posedge clk)
  begin
    gap = gap + 1;
    if (ir_tx && !prev)
    begin
      if (seen)
        repeat (gap / bit_clk - 1) cap_q.push_back(1'b1);
      cap_q.push_back(1'b0);
      gap = 0;
      seen = 1;
    end
    prev = ir_tx;
  end

  // Windows of 42, 42, 41 samples; the line is dark between frames.
  initial
  begin
    int ph;
    int len;
    bit b;
    ph = 0;
    ir_rx = 1'b0;
    forever
    begin
      @(posedge clk);
      if (out_q.size() != 0)
      begin
        b = out_q.pop_front();
        len = (ph == 2) ? 41 : 42;
        ph = (ph + 1) % 3;
        ir_rx <= !b;
        repeat (10) @(posedge clk);
        ir_rx <= 1'b0;
        repeat (len - 11) @(posedge clk);
      end
    end
  end
endmodule

// *** test/irm_framer_tb.sv ***
`timescale 1ns/1ps

module irm_framer_tb;
  logic clk;
  logic reset;
  logic clk_en;
  irm_pkg::irm_bus_t bus;
  logic [31:0] rdata;
  logic ir_rx;
  logic ir_tx;
  int num_errors = 0;
  int checks_done = 0;
  int ones;
  bit exp_q[$];
  logic [31:0] words[$];
  logic [31:0] d;

  irm_framer irm_framer_i (.clk(clk), .reset(reset), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .ir_rx(ir_rx), .ir_tx(ir_tx));
  irm_link_model irm_link_model_i (.clk(clk), .ir_tx(ir_tx), .ir_rx(ir_rx));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{re: 1'b0, we: 1'b1, addr: a, wdata: v};
    @(posedge clk);
    bus <= '0;
  endtask

  // The strobe is dropped before sampling so the next call can start cleanly.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{re: 1'b1, we: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, d);
    cmp(d & m, e);
  endtask

  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    rd(a, d);
    while (d[b] !== v)
    begin
      n++;
      if (n == 2000)
      begin
        cmp({31'h0, d[b]}, {31'h0, v});
        end_of_test();
      end
      rd(a, d);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [15:0] v, input int n, input bit msb, input bit stuff);
    bit b;
    for (int i = 0; i < n; i++)
    begin
      b = msb ? v[n-1-i] : v[i];
      exp_q.push_back(b);
      ones = b ? ones + 1 : 0;
      if (stuff && ones == 5)
      begin
        exp_q.push_back(1'b0);
        ones = 0;
      end
    end
  endtask

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] v);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ v[i]) ? 16'h1021 : 16'h0000);
    return r;
  endfunction

  // Line image of a whole frame; extra zeros push the closing flag off the byte grid.
  task automatic build(input logic [7:0] body[$], input bit bad, input int extra);
    logic [15:0] c;
    c = 16'hFFFF;
    exp_q.delete();
    put(16'h007E, 8, 1'b0, 1'b0);
    put(16'h007E, 8, 1'b0, 1'b0);
    ones = 0;
    foreach (body[i])
    begin
      put({8'h00, body[i]}, 8, 1'b0, 1'b1);
      c = crc_step(c, body[i]);
    end
    put(c ^ {15'h0, bad}, 16, 1'b1, 1'b1);
    repeat (extra) exp_q.push_back(1'b0);
    put(16'h007E, 8, 1'b0, 1'b0);
  endtask

  function automatic bit found(input bit c[$]);
    int k;
    for (int s = 0; s + exp_q.size() <= c.size(); s++)
    begin
      k = 0;
      while (k < exp_q.size() && c[s+k] == exp_q[k])
        k++;
      if (k == exp_q.size())
        return 1'b1;
    end
    return 1'b0;
  endfunction

  task automatic tx_frame(input logic [7:0] body[$], input int ndata);
    irm_link_model_i.cap_q.delete();
    for (int i = 0; i < ndata; i++)
    begin
      wait_bit(irm_pkg::REG_TXDATA, 0, 1'b0);
      wr(irm_pkg::REG_TXDATA, {24'h0, body[i]});
    end
    wait_bit(irm_pkg::REG_STATUS, 0, 1'b1);
    repeat (200) @(posedge clk);
    build(body, 1'b0, 0);
    cmp({31'h0, found(irm_link_model_i.cap_q)}, 32'h1);
    wr(irm_pkg::REG_STATUS, 32'h1F);
    chk(irm_pkg::REG_STATUS, 32'h1, 32'h0);
  endtask

  task automatic rx_frame(input logic [7:0] body[$], input bit bad, input int extra);
    build(body, bad, extra);
    words.delete();
    irm_link_model_i.out_q = exp_q;
    for (int i = 0; i < exp_q.size() * 21 + 600; i++)
    begin
      rd(irm_pkg::REG_RXDATA, d);
      if (d[11] === 1'b1)
        words.push_back(d);
    end
  endtask

  task automatic rx_check(input logic [7:0] body[$], input logic [31:0] last);
    cmp(32'(words.size()), 32'(body.size()));
    foreach (body[i])
      cmp(words[i], {20'h0, 4'h8, body[i]} | (i == body.size() - 1 ? last : 32'h0));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_en = 1'b1;
    reset = 1'b1;
    bus = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a <= 16; a += 4)
      chk(8'(a), 32'hFFFFFFFF, 32'h0);
    chk(8'h40, 32'hFFFFFFFF, 32'h0);
    wr(irm_pkg::REG_TAIL1, 32'hAA);
    wr(irm_pkg::REG_ADDR, 32'h42);
    chk(irm_pkg::REG_ADDR, 32'hFF, 32'h42);
    // A write while the clock enable is low must leave the address untouched.
    clk_en <= 1'b0;
    wr(irm_pkg::REG_ADDR, 32'h99);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk(irm_pkg::REG_ADDR, 32'hFF, 32'h42);
    wr(irm_pkg::REG_CTRL, 32'h16);
    chk(irm_pkg::REG_CTRL, 32'h3F, 32'h16);
    wr(irm_pkg::REG_TAIL2, 32'h7E81);
    tx_frame('{8'h3C, 8'hF8, 8'hFF, 8'h81, 8'h7E}, 3);
    wr(irm_pkg::REG_CTRL, 32'h06);
    irm_link_model_i.bit_clk = 8;
    tx_frame('{8'hFF}, 1);
    wr(irm_pkg::REG_CTRL, 32'h2E);
    rx_frame('{8'h42, 8'h7C, 8'hFF}, 1'b0, 0);
    rx_check('{8'h42, 8'h7C, 8'hFF}, 32'h100);
    chk(irm_pkg::REG_STATUS, 32'h6, 32'h2);
    wr(irm_pkg::REG_STATUS, 32'h1F);
    rx_frame('{8'h13, 8'h55}, 1'b0, 0);
    cmp(32'(words.size()), 32'h0);
    rx_frame('{8'hFF}, 1'b1, 0);
    rx_check('{8'hFF}, 32'h300);
    chk(irm_pkg::REG_STATUS, 32'h4, 32'h4);
    wr(irm_pkg::REG_STATUS, 32'h1F);
    rx_frame('{8'hFF, 8'h11, 8'h22, 8'h33}, 1'b0, 3);
    cmp(words[$] & 32'h500, 32'h500);
    chk(irm_pkg::REG_STATUS, 32'h8, 32'h8);
    end_of_test();
  end
endmodule
